// *** design/interval_timebase_timer.v ***
// Interval timer / real-time-clock time base with divided clock output and APB registers
//
// Register access over APB was decided locally.
`timescale 1ns/1ps
`include "itimer_map.vh"

module interval_timebase_timer #(
    parameter ADDR_W = 18
) (
    // Clock and reset
    input wire mclk,
    input wire nrst,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Power mode from the system controller, same clock domain
    input wire [2:0] pwr_mode,
    // 32.768 kHz subclock pin, asynchronous
    input wire subclk_in,
    // Divided clock output pin and interrupt
    output reg divided_clock_out,
    output wire timer_a_irq
);

    localparam [ADDR_W-1:0] MODE_ADDR = {`MODE_SEL_IDX, 2'b00};
    localparam [ADDR_W-1:0] COUNT_ADDR = {`COUNT_VAL_IDX, 2'b00};
    localparam [ADDR_W-1:0] IRQ_ADDR = {`IRQ_CTRL_IDX, 2'b00};

    // Tap hit when the low n bits of a prescaler are all ones
    function tap_hit;
        input [`SUB_PRESC_W-1:0] cnt;
        input [3:0] n;
        reg [`SUB_PRESC_W-1:0] mask;
        begin
            mask = ({`SUB_PRESC_W{1'b1}} >> (`SUB_PRESC_W - n));
            tap_hit = ((cnt & mask) == mask);
        end
    endfunction

    // Prescaler bit for the clock output; code 0 gives the divide-by-32 tap
    function [2:0] out_bit;
        input [1:0] sel;
        begin
            out_bit = `CLKOUT_TOP_BIT - {1'b0, sel};
        end
    endfunction

    // Reset synchroniser
    reg rst_s1_q;
    reg rst_n_q;
    always @(posedge mclk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s1_q <= 1'b0;
            rst_n_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_n_q <= rst_s1_q;
        end
    end

    // Subclock synchroniser and edge detect
    reg sub_s1_q;
    reg sub_s2_q;
    reg sub_s3_q;
    wire sub_edge;
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            sub_s1_q <= 1'b0;
            sub_s2_q <= 1'b0;
            sub_s3_q <= 1'b0;
        end
        else
        begin
            sub_s1_q <= subclk_in;
            sub_s2_q <= sub_s1_q;
            sub_s3_q <= sub_s2_q;
        end
    end
    // Edges seen on the system clock, so a count may slip by one mclk period
    assign sub_edge = sub_s2_q & ~sub_s3_q;

    // Power mode decode
    wire sys_run;
    wire tb_run;
    wire sub_out_ok;
    assign sys_run = (pwr_mode == `PM_ACTIVE) || (pwr_mode == `PM_SLEEP);
    assign tb_run = (pwr_mode != `PM_STANDBY);
    assign sub_out_ok = sys_run || (pwr_mode == `PM_SUBACTIVE);

    // Registers
    reg [7:0] mode_q;
    reg [7:0] count_q;
    reg [7:0] count_d;
    reg irq_flag_q;
    reg irq_en_q;
    reg clkout_en_q;
    reg [`SYS_PRESC_W-1:0] pss_q;
    reg [`SUB_PRESC_W-1:0] psw_q;

    wire tb_mode;
    wire cnt_clear;
    assign tb_mode = mode_q[`MODE_TB_BIT];
    assign cnt_clear = tb_mode & mode_q[`MODE_CLR_BIT];

    // APB decode
    wire wr_en;
    wire hit_mode;
    wire hit_count;
    wire hit_irq;
    assign hit_mode = (paddr == MODE_ADDR);
    assign hit_count = (paddr == COUNT_ADDR);
    assign hit_irq = (paddr == IRQ_ADDR);
    // Zero wait states: every register answers in the access cycle
    assign pready = 1'b1;
    assign pslverr = psel & penable & ~(hit_mode | hit_count | hit_irq);
    assign wr_en = psel & penable & pwrite;

    // System prescaler; stops with the system clock outside active/sleep
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            pss_q <= {`SYS_PRESC_W{1'b0}};
        else if (sys_run)
            pss_q <= pss_q + 1'b1;
    end

    // Subclock prescaler
    // Counts in every power mode so the time base keeps its phase; the time-base clear resets it
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            psw_q <= {`SUB_PRESC_W{1'b0}};
        else if (cnt_clear)
            psw_q <= {`SUB_PRESC_W{1'b0}};
        else if (sub_edge)
            psw_q <= psw_q + 1'b1;
    end

    // Count input selection
    reg [3:0] sys_log2;
    reg [3:0] sub_log2;
    always @*
    begin
        case (mode_q[2:0])
            3'h0: sys_log2 = `ITV_TAP0_LOG2;
            3'h1: sys_log2 = `ITV_TAP1_LOG2;
            3'h2: sys_log2 = `ITV_TAP2_LOG2;
            3'h3: sys_log2 = `ITV_TAP3_LOG2;
            3'h4: sys_log2 = `ITV_TAP4_LOG2;
            3'h5: sys_log2 = `ITV_TAP5_LOG2;
            3'h6: sys_log2 = `ITV_TAP6_LOG2;
            default: sys_log2 = `ITV_TAP7_LOG2;
        endcase
        case (mode_q[1:0])
            2'h0: sub_log2 = `TB_1S_LOG2;
            2'h1: sub_log2 = `TB_HALF_LOG2;
            2'h2: sub_log2 = `TB_QUARTER_LOG2;
            default: sub_log2 = `TB_FAST_LOG2;
        endcase
    end

    wire sys_tick;
    wire sub_tick;
    wire cnt_tick;
    // Interval ticks need the system clock; time base ticks stop only in standby
    assign sys_tick = sys_run & tap_hit({2'b00, pss_q}, sys_log2);
    assign sub_tick = sub_edge & tap_hit(psw_q, sub_log2);
    assign cnt_tick = tb_mode ? (tb_run & sub_tick) : sys_tick;

    wire overflow;
    // A clear in the same cycle as the wrap suppresses the overflow
    assign overflow = cnt_tick & ~cnt_clear & (count_q == 8'hFF);

    always @*
    begin
        count_d = count_q;
        if (cnt_clear)
            count_d = 8'h00;
        else if (cnt_tick)
            count_d = count_q + 8'h01;
    end

    // Counter; bus writes never reach it
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            count_q <= `COUNT_VAL_RST;
        else
            count_q <= count_d;
    end

    // Mode register; reserved bit forced high
    wire mode_wr_ok;
    assign mode_wr_ok = (pwr_mode == `PM_ACTIVE) || (pwr_mode == `PM_SUBACTIVE);
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            mode_q <= `MODE_SEL_RST;
        else if (wr_en & hit_mode & mode_wr_ok)
        begin
            mode_q <= pwdata[7:0] | (8'h01 << `MODE_RSVD_BIT);
        end
    end

    // Interrupt flag: write one to clear, a same-cycle overflow wins
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
        begin
            irq_flag_q <= 1'b0;
            irq_en_q <= 1'b0;
            clkout_en_q <= 1'b0;
        end
        else
        begin
            if (overflow)
                irq_flag_q <= 1'b1;
            else if (wr_en & hit_irq & pwdata[`IRQ_FLAG_BIT])
                irq_flag_q <= 1'b0;
            if (wr_en & hit_irq)
            begin
                irq_en_q <= pwdata[`IRQ_EN_BIT];
                clkout_en_q <= pwdata[`CLKOUT_EN_BIT];
            end
        end
    end

    assign timer_a_irq = irq_flag_q & irq_en_q;

    // Read data, captured in the setup cycle
    reg [7:0] rd_val;
    always @*
    begin
        rd_val = 8'h00;
        if (hit_mode)
            rd_val = mode_q | 8'h10;
        else if (hit_count)
            // Subactive reads give zero; the slow clock leaves no stable value
            rd_val = (pwr_mode == `PM_SUBACTIVE) ? 8'h00 : count_q;
        else if (hit_irq)
            rd_val = {5'h00, clkout_en_q, irq_en_q, irq_flag_q};
    end

    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            prdata <= 32'h00000000;
        else if (psel & ~penable)
            prdata <= {24'h000000, rd_val};
    end

    // Divided clock output
    wire [2:0] out_idx;
    assign out_idx = out_bit(mode_q[6:5]);
    reg clk_sel;
    always @*
    begin
        if (mode_q[7])
            clk_sel = sub_out_ok & psw_q[out_idx];
        else
            clk_sel = sys_run & pss_q[out_idx];
    end

    // Registered so the pin is glitch free while the selection changes
    always @(posedge mclk or negedge rst_n_q)
    begin
        if (!rst_n_q)
            divided_clock_out <= 1'b0;
        else
            divided_clock_out <= clkout_en_q & clk_sel;
    end

endmodule // interval_timebase_timer

// *** design/itimer_map.vh ***
// Register map, field positions, reset values and timing figures of the interval/time-base timer
`ifndef ITIMER_MAP_VH
`define ITIMER_MAP_VH
// Register indices; byte address is four times the index
`define MODE_SEL_IDX 16'hFFB0
`define COUNT_VAL_IDX 16'hFFB1
`define IRQ_CTRL_IDX 16'hFFB2
`define MODE_SEL_RST 8'h10
`define COUNT_VAL_RST 8'h00
`define IRQ_CTRL_RST 8'h00
`define MODE_RSVD_BIT 4
`define MODE_TB_BIT 3
`define MODE_CLR_BIT 2
// Interrupt/port control fields
`define IRQ_FLAG_BIT 0
`define IRQ_EN_BIT 1
`define CLKOUT_EN_BIT 2
// Power modes
`define PM_ACTIVE 3'h0
`define PM_SLEEP 3'h1
`define PM_WATCH 3'h2
`define PM_SUBACTIVE 3'h3
`define PM_SUBSLEEP 3'h4
`define PM_STANDBY 3'h5
// Prescaler widths and time-base tap exponents of the subclock
`define SYS_PRESC_W 13
`define SUB_PRESC_W 15
`define TB_1S_LOG2 4'h7
`define TB_HALF_LOG2 4'h6
`define TB_QUARTER_LOG2 4'h5
`define TB_FAST_LOG2 4'h2
// Interval tap exponents of the system prescaler, codes 0 to 7
`define ITV_TAP0_LOG2 4'hD
`define ITV_TAP1_LOG2 4'hC
`define ITV_TAP2_LOG2 4'hB
`define ITV_TAP3_LOG2 4'h9
`define ITV_TAP4_LOG2 4'h8
`define ITV_TAP5_LOG2 4'h7
`define ITV_TAP6_LOG2 4'h5
`define ITV_TAP7_LOG2 4'h3
// Prescaler bit that gives the slowest clock output
`define CLKOUT_TOP_BIT 3'h4
`endif

// *** sim/itimer_assertions.sv ***
// Port-level checks of the interval timer
`timescale 1ns/1ps
module itimer_assertions #(parameter ADDR_W = 18) (
    // Clock, reset, bus
    input wire mclk,
    input wire nrst,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [ADDR_W-1:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    // Mode and outputs
    input wire [2:0] pwr_mode,
    input wire divided_clock_out,
    input wire timer_a_irq
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    wire acc = psel && penable;
    wire ctl_wr = acc && pwrite && paddr == 18'h3FEC8;
    wire cnt_rd = acc && !pwrite && paddr == 18'h3FEC4;
    a_rsvd_read: assert property (acc && !pwrite && paddr == 18'h3FEC0 |-> prdata[4])
        else $error("reserved mode bit read low");
    a_sub_read: assert property (cnt_rd && pwr_mode == 3'h3 |-> prdata == 0)
        else $error("count read in subactive not zero");
    a_clk_idle: assert property ((pwr_mode == 3'h2 || pwr_mode > 3'h3) [*2] |-> !divided_clock_out)
        else $error("clock output active in a stopped mode");
    a_irq_clear: assert property ($fell(timer_a_irq) |-> $past(ctl_wr))
        else $error("interrupt dropped without a control write");
    a_irq_hold: assert property (timer_a_irq && !ctl_wr |=> timer_a_irq)
        else $error("interrupt request lost");
    a_irq_off: assert property (ctl_wr && !pwdata[1] |=> !timer_a_irq)
        else $error("interrupt with enable cleared");
    a_clr_read: assert property (acc && pwrite && paddr == 18'h3FEC0 && pwdata[3:2] == 2'h3
        && pwr_mode == 3'h0 ##3 cnt_rd && pwr_mode == 3'h0 |-> prdata == 0)
        else $error("count not held at zero");
    a_out_gate: assert property (ctl_wr && !pwdata[2] |=> ##1 !divided_clock_out [*2])
        else $error("clock output while disabled");
endmodule // itimer_assertions
bind interval_timebase_timer itimer_assertions #(.ADDR_W(ADDR_W)) chk (.mclk(mclk), .nrst(nrst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pwr_mode(pwr_mode), .divided_clock_out(divided_clock_out),
    .timer_a_irq(timer_a_irq));

// *** sim/testbench.sv ***
// Self-checking bench of the interval timer
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
    $display("ERROR %0t got %h want %h", $time, a, b); end end
module testbench;
    logic mclk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, subclk_in = 0, err;
    logic [17:0] paddr = 0;
    logic [31:0] pwdata = 0, rdat;
    logic [2:0] pwr_mode = 0;
    logic [1:0] sdiv = 0;
    wire pready, pslverr, divided_clock_out, timer_a_irq;
    wire [31:0] prdata;
    int fails = 0, checks_done = 0, n;
    localparam [17:0] MODE = 18'h3FEC0, CNT = 18'h3FEC4, CTL = 18'h3FEC8;
    interval_timebase_timer uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .pwr_mode(pwr_mode), .subclk_in(subclk_in),
        .divided_clock_out(divided_clock_out), .timer_a_irq(timer_a_irq));
    initial forever #2.5 mclk = ~mclk;
    // Subclock at mclk/8 so its divided rates come out exact
    always @(posedge mclk)
    begin
        sdiv <= sdiv + 2'h1;
        if (sdiv == 2'h3) subclk_in <= ~subclk_in;
    end
    task apb(input logic w, input logic [17:0] a, input logic [7:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1;
        do @(posedge mclk); while (pready !== 1'b1);
        rdat = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge mclk);
    endtask
    task rd(input logic [17:0] a, input logic [31:0] e);
        apb(0, a, 8'h00);
        `CHK(rdat, e)
    endtask
    task rises(input int len, output int r);
        logic p;
        r = 0;
        repeat (8) @(posedge mclk);
        p = divided_clock_out;
        repeat (len)
        begin
            @(posedge mclk);
            r += (divided_clock_out && !p);
            if ($isunknown(divided_clock_out)) r += 100;
            p = divided_clock_out;
        end
    endtask
    task t_regs;
        rd(MODE, 32'h10);
        `CHK(err, 1'b0)
        rd(CNT, 32'h0);
        apb(1, CNT, 8'h55);
        rd(CNT, 32'h0);
        apb(1, MODE, 8'hEF);
        rd(MODE, 32'hFF);
        apb(1, MODE, 8'h0C);
        rd(CNT, 32'h0);
        pwr_mode <= 3'h1;
        apb(1, MODE, 8'h00);
        pwr_mode <= 3'h0;
        rd(MODE, 32'h1C);
        rd(18'h0, 32'h0);
        `CHK(err, 1'b1)
    endtask
    task t_ovf;
        apb(1, CTL, 8'h03);
        apb(1, MODE, 8'h07);
        n = 0;
        while (timer_a_irq !== 1'b1 && n < 3000)
        begin
            @(posedge mclk);
            n++;
        end
        `CHK(n >= 2030 && n <= 2050, 1'b1)
        apb(1, CTL, 8'h00);
        `CHK(timer_a_irq, 1'b0)
        apb(1, CTL, 8'h02);
        `CHK(timer_a_irq, 1'b1)
        apb(1, CTL, 8'h03);
        `CHK(timer_a_irq, 1'b0)
    endtask
    task t_clk;
        apb(1, CTL, 8'h04);
        for (int c = 0; c < 8; c++)
        begin
            apb(1, MODE, {c[2:0], 5'h07});
            rises(512, n);
            `CHK(n, c < 4 ? 512 >> (5 - c) : 64 >> (9 - c))
        end
        pwr_mode <= 3'h3;
        rises(64, n);
        `CHK(n, 2)
        pwr_mode <= 3'h2;
        rises(64, n);
        `CHK(n, 0)
        pwr_mode <= 3'h3;
        apb(1, MODE, 8'h67);
        rises(64, n);
        `CHK(n, 0)
        pwr_mode <= 3'h1;
        rises(64, n);
        `CHK(n, 16)
        pwr_mode <= 3'h0;
        apb(1, CTL, 8'h00);
        rises(64, n);
        `CHK(n, 0)
    endtask
    task t_base;
        int v;
        apb(1, MODE, 8'h0C);
        apb(1, MODE, 8'h0B);
        repeat (320) @(posedge mclk);
        apb(0, CNT, 8'h00);
        `CHK(rdat >= 9 && rdat <= 11, 1'b1)
        v = rdat;
        // Standby halts the time base, watch does not: about four ticks expected
        pwr_mode <= 3'h5;
        repeat (128) @(posedge mclk);
        pwr_mode <= 3'h2;
        repeat (128) @(posedge mclk);
        pwr_mode <= 3'h3;
        rd(CNT, 32'h0);
        pwr_mode <= 3'h0;
        apb(0, CNT, 8'h00);
        `CHK(rdat - v >= 3 && rdat - v <= 6, 1'b1)
        apb(1, MODE, 8'h0F);
        rd(CNT, 32'h0);
    endtask
    task conclude;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge mclk);
        nrst <= 1;
        repeat (3) @(posedge mclk);
        t_regs;
        t_ovf;
        t_clk;
        t_base;
        conclude;
    end
    // Whole run needs about 7500 cycles, under 40 us
    initial
    begin
        #100000;
        fails++;
        conclude;
    end
endmodule // testbench
